// ==== src/cbp_balance_pwm.v ====
// Purpose: Duty-cycle control of the cell-balancing switches of channels 8 to 14, over AXI4-Lite.
// Assumes: One clock at 25 MHz, synchronous active-low reset; the bus master obeys AXI4-Lite.
// Notes: Register byte address is four times the word index; unmapped addresses answer SLVERR.
`timescale 1ns/10ps
`include "cbp_consts.vh"

module cbp_balance_pwm #(
    parameter [15:0] PRESCALE = 16'h0001
)
(
    input wire aclk,
    input wire aresetn,
    input wire [15:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [15:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire [6:0] balance_gate
);

    localparam NCHAN = 7;

    // Write channel holding registers.
    reg aw_full_reg;
    reg [15:0] aw_addr_reg;
    reg w_full_reg;
    reg [7:0] w_duty_reg;
    reg w_lane0_reg;

    // Duty fields of all channels, channel 8 in the lowest byte.
    reg [8*NCHAN-1:0] duty_reg;

    // Period counter outputs.
    wire [7:0] count;
    wire period_end;

    // Write decode.
    wire aw_take;
    wire w_take;
    wire do_write;
    wire [13:0] wr_idx;
    wire [13:0] wr_off;
    wire wr_is_duty;
    wire [2:0] wr_chan;

    // Read decode.
    wire ar_take;
    wire [13:0] rd_idx;
    wire [13:0] rd_off;
    wire rd_is_duty;
    wire rd_is_status;
    wire [2:0] rd_chan;
    reg [31:0] rdata_next;
    reg [1:0] rresp_next;

    // Loop index of the reset loop alone, so that only one process ever drives it.
    integer i;

    // Address and data are taken independently, each once per write.
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    // The write lands once both halves are held and no response is pending.
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;

    // Offsets below the first channel wrap to large values and fail the range test.
    assign wr_idx = aw_addr_reg[15:2];
    assign wr_off = wr_idx - `CBP_DUTY_IDX_CH8;
    assign wr_is_duty = (wr_off < `CBP_CHAN_COUNT);
    assign wr_chan = wr_off[2:0];

    // Capture of the address and data halves of a write.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 16'h0000;
            w_full_reg <= 1'b0;
            w_duty_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_full_reg <= 1'b0;
            end
            if (w_take)
            begin
                w_full_reg <= 1'b1;
                // Only the duty byte is kept; bits 31:8 have no storage at all.
                w_duty_reg <= s_axi_wdata[`CBP_DUTY_MSB:`CBP_DUTY_LSB];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            else if (do_write)
            begin
                w_full_reg <= 1'b0;
            end
        end
    end

    // Duty registers; a write with byte lane 0 disabled leaves the field untouched.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (i = 0; i < NCHAN; i = i + 1)
            begin
                duty_reg[8*i +: 8] <= `CBP_DUTY_RESET;
            end
        end
        else if (do_write && wr_is_duty && w_lane0_reg)
        begin
            // The range test keeps wr_chan below seven, so the default branch never changes a field.
            case (wr_chan)
                3'h0:
                begin
                    duty_reg[7:0] <= w_duty_reg;
                end
                3'h1:
                begin
                    duty_reg[15:8] <= w_duty_reg;
                end
                3'h2:
                begin
                    duty_reg[23:16] <= w_duty_reg;
                end
                3'h3:
                begin
                    duty_reg[31:24] <= w_duty_reg;
                end
                3'h4:
                begin
                    duty_reg[39:32] <= w_duty_reg;
                end
                3'h5:
                begin
                    duty_reg[47:40] <= w_duty_reg;
                end
                3'h6:
                begin
                    duty_reg[55:48] <= w_duty_reg;
                end
                default:
                begin
                    duty_reg <= duty_reg;
                end
            endcase
        end
    end

    // Write response; the status register is read-only and writes to it are ignored with OKAY.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CBP_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_is_duty || (wr_idx == `CBP_STATUS_IDX)) ? `CBP_RESP_OKAY : `CBP_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // A new read is taken only when no read data wait for the master.
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[15:2];
    assign rd_off = rd_idx - `CBP_DUTY_IDX_CH8;
    assign rd_is_duty = (rd_off < `CBP_CHAN_COUNT);
    assign rd_is_status = (rd_idx == `CBP_STATUS_IDX);
    assign rd_chan = rd_off[2:0];

    // Read data selection; everything above the duty byte reads as zero.
    always @*
    begin
        rdata_next = 32'h00000000;
        rresp_next = `CBP_RESP_OKAY;
        if (rd_is_duty)
        begin
            // Only the duty byte is ever filled in; the upper bits keep the zero set above.
            case (rd_chan)
                3'h0:
                begin
                    rdata_next[`CBP_DUTY_MSB:`CBP_DUTY_LSB] = duty_reg[7:0];
                end
                3'h1:
                begin
                    rdata_next[`CBP_DUTY_MSB:`CBP_DUTY_LSB] = duty_reg[15:8];
                end
                3'h2:
                begin
                    rdata_next[`CBP_DUTY_MSB:`CBP_DUTY_LSB] = duty_reg[23:16];
                end
                3'h3:
                begin
                    rdata_next[`CBP_DUTY_MSB:`CBP_DUTY_LSB] = duty_reg[31:24];
                end
                3'h4:
                begin
                    rdata_next[`CBP_DUTY_MSB:`CBP_DUTY_LSB] = duty_reg[39:32];
                end
                3'h5:
                begin
                    rdata_next[`CBP_DUTY_MSB:`CBP_DUTY_LSB] = duty_reg[47:40];
                end
                3'h6:
                begin
                    rdata_next[`CBP_DUTY_MSB:`CBP_DUTY_LSB] = duty_reg[55:48];
                end
                default:
                begin
                    rdata_next = 32'h00000000;
                end
            endcase
        end
        else if (rd_is_status)
        begin
            rdata_next[NCHAN-1:0] = balance_gate;
        end
        else
        begin
            rresp_next = `CBP_RESP_SLVERR;
        end
    end

    // Read answer registered in the cycle after the address is taken.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CBP_RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // One counter serves all channels, so every channel's period starts together.
    cbp_period_cnt #(
        .PRESCALE(PRESCALE)
    )
    u_period (
        .aclk(aclk),
        .aresetn(aresetn),
        .count_reg(count),
        .period_end(period_end)
    );

    // One comparator per channel.
    genvar g;
    generate
        for (g = 0; g < NCHAN; g = g + 1)
        begin : g_chan
            cbp_pwm_chan u_chan (
                .aclk(aclk),
                .aresetn(aresetn),
                .count(count),
                .period_end(period_end),
                .duty(duty_reg[8*g +: 8]),
                .gate_reg(balance_gate[g])
            );
        end
    endgenerate

endmodule // cbp_balance_pwm

// ==== src/cbp_consts.vh ====
// Purpose: Shared constants of the cell-balance duty block: register indices, field layout, reset values.
// Assumes: Register indices are word indices; the byte address on the bus is four times the index.
// Notes: Definitions only, guarded against double inclusion.
`ifndef CBP_CONSTS_VH
`define CBP_CONSTS_VH

// Word indices of the seven duty registers, channel 8 through channel 14.
`define CBP_DUTY_IDX_CH8 14'h103B
`define CBP_DUTY_IDX_CH9 14'h103C
`define CBP_DUTY_IDX_CH10 14'h103D
`define CBP_DUTY_IDX_CH11 14'h103E
`define CBP_DUTY_IDX_CH12 14'h103F
`define CBP_DUTY_IDX_CH13 14'h1040
`define CBP_DUTY_IDX_CH14 14'h1041
// Number of duty registers in this block, at the index width.
`define CBP_CHAN_COUNT 14'h0007

// Word index of the read-only gate status register.
`define CBP_STATUS_IDX 14'h1080

// Duty field position and width; bits above it read as zero.
`define CBP_DUTY_LSB 0
`define CBP_DUTY_MSB 7
`define CBP_DUTY_WIDTH 8

// Duty codes: reset value (full duty), half duty and off.
`define CBP_DUTY_RESET 8'hFF
`define CBP_HALF_DUTY_CODE 8'h80
`define CBP_DUTY_OFF 8'h00

// Last count of the period counter: 255 steps, 0 through 254.
`define CBP_PERIOD_LAST 8'hFE

// Bus response codes.
`define CBP_RESP_OKAY 2'h0
`define CBP_RESP_SLVERR 2'h2

`endif

// ==== src/cbp_period_cnt.v ====
// Purpose: Free-running period counter shared by all balancing channels.
// Assumes: One clock; the step rate is the clock divided by PRESCALE.
// Notes: Counts 0 through 254, so one period is 255 steps.
`timescale 1ns/10ps
`include "cbp_consts.vh"

module cbp_period_cnt #(
    parameter [15:0] PRESCALE = 16'h0001
)
(
    input wire aclk,
    input wire aresetn,
    output reg [7:0] count_reg,
    output wire period_end
);

    reg [15:0] pre_reg;
    wire step;

    // A step enable pulse once every PRESCALE clocks.
    assign step = (pre_reg == PRESCALE - 16'h0001);
    // The last step of a period is where new duty values are taken.
    assign period_end = step && (count_reg == `CBP_PERIOD_LAST);

    // Prescaler and step counter.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pre_reg <= 16'h0000;
            count_reg <= 8'h00;
        end
        else
        begin
            pre_reg <= step ? 16'h0000 : pre_reg + 16'h0001;
            if (step)
            begin
                count_reg <= (count_reg == `CBP_PERIOD_LAST) ? 8'h00 : count_reg + 8'h01;
            end
        end
    end

endmodule // cbp_period_cnt

// ==== src/cbp_pwm_chan.v ====
// Purpose: One balancing channel: compares its duty value with the shared period count.
// Assumes: count runs 0 through 254; period_end marks the last step of a period.
// Notes: The duty value is taken only at period boundaries, so a write never cuts a pulse short.
`timescale 1ns/10ps
`include "cbp_consts.vh"

module cbp_pwm_chan (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] count,
    input wire period_end,
    input wire [7:0] duty,
    output reg gate_reg
);

    reg [7:0] active_reg;

    // Duty shadow, loaded at the end of each period.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            active_reg <= `CBP_DUTY_RESET;
        end
        else if (period_end)
        begin
            active_reg <= duty;
        end
    end

    // Gate is on while the count is below the duty: 0 never on, 255 always on, 128 gives 128 of 255 steps.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gate_reg <= 1'b0;
        end
        else
        begin
            gate_reg <= (count < active_reg);
        end
    end

endmodule // cbp_pwm_chan

// ==== tb/cbp_balance_pwm_props.sv ====
// Purpose: Bus handshake and readback checks on the duty block ports.
// Assumes: One clock, synchronous active-low reset.
// Notes: Gate timing needs the duty values, so the bench judges it.
`timescale 1ns/10ps
module cbp_balance_pwm_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data of one write taken at the same edge.
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    // The upper bits are never set, whatever was written.
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("reserved bits set");
    err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000)
        else $error("error read with data");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
endmodule // cbp_balance_pwm_props

bind cbp_balance_pwm cbp_balance_pwm_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// ==== tb/cbp_balance_pwm_tb_top.sv ====
// Purpose: Self-checking bench of the duty block over its bus and gates.
// Assumes: PRESCALE 1, so one period is 255 clocks.
// Notes: On-time is counted over a whole period window once a duty has settled.
`timescale 1ns/10ps
`include "cbp_consts.vh"
module cbp_balance_pwm_tb_top;
    localparam [55:0] DUTY = 56'h407FFE01FF8000;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    reg [31:0] wdata = 32'h00000000, d;
    reg [3:0] wstrb = 4'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [1:0] r;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [6:0] gate;
    integer n_errors = 0, num_checks = 0;
    cbp_balance_pwm #(.PRESCALE(16'h0001)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .balance_gate(gate));
    // Free-running 25 MHz clock.
    initial
        forever #20 aclk = ~aclk;
    function [15:0] ch_addr(input integer i);
        ch_addr = {`CBP_DUTY_IDX_CH8 + i[13:0], 2'b00};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk_resp(input [1:0] got, input [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask
    // Offers address and data together and holds each until taken; a hang counts as a mismatch.
    task wr(input [15:0] a, input [31:0] v, input [3:0] s);
        integer t;
        reg done;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= v;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            done = 1'b0;
            for (t = 0; t < 100 && !done; t = t + 1)
            begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid === 1'b1)
                begin
                    r = bresp;
                    bready <= 1'b0;
                    done = 1'b1;
                end
            end
            if (!done)
            begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t write not answered", $time);
            end
        end
    endtask
    // Holds the read address until taken and rready until the data come.
    task rd(input [15:0] a);
        integer t;
        reg done;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            done = 1'b0;
            for (t = 0; t < 100 && !done; t = t + 1)
            begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
                if (rvalid === 1'b1)
                begin
                    d = rdata;
                    r = rresp;
                    rready <= 1'b0;
                    done = 1'b1;
                end
            end
            if (!done)
            begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t read not answered", $time);
            end
        end
    endtask
    // Two periods let a new duty take effect; any 255-step window then holds exactly duty steps on.
    task gate_check(input [55:0] e);
        integer i, k;
        reg [7:0] c [0:6];
        begin
            repeat (520) @(posedge aclk);
            for (i = 0; i < 7; i = i + 1)
                c[i] = 8'h00;
            for (k = 0; k < 255; k = k + 1)
            begin
                @(posedge aclk);
                for (i = 0; i < 7; i = i + 1)
                    c[i] = c[i] + gate[i];
            end
            for (i = 0; i < 7; i = i + 1)
                chk({24'h0, c[i]}, {24'h0, e[8*i +: 8]});
        end
    endtask
    task t_reset;
        integer i;
        begin
            for (i = 0; i < 7; i = i + 1)
            begin
                rd(ch_addr(i));
                chk(d, 32'h000000FF);
                chk_resp(r, `CBP_RESP_OKAY);
            end
            gate_check({7{8'hFF}});
            // At full duty every gate stands high, so the status word is steady.
            rd({`CBP_STATUS_IDX, 2'b00});
            chk(d, 32'h0000007F);
            $display("reset test done");
        end
    endtask
    task t_duty;
        integer i;
        begin
            for (i = 0; i < 7; i = i + 1)
            begin
                wr(ch_addr(i), {24'hA5A5A5, DUTY[8*i +: 8]}, 4'hF);
                chk_resp(r, `CBP_RESP_OKAY);
            end
            for (i = 0; i < 7; i = i + 1)
            begin
                rd(ch_addr(i));
                chk(d, {24'h000000, DUTY[8*i +: 8]});
            end
            gate_check(DUTY);
            $display("duty test done");
        end
    endtask
    // Strobe off leaves the field; the word after channel 14 is not decoded here.
    task t_edge;
        begin
            wr(ch_addr(0), 32'h00000033, 4'h0);
            rd(ch_addr(0));
            chk(d, 32'h00000000);
            wr(ch_addr(7), 32'h00000033, 4'hF);
            chk_resp(r, `CBP_RESP_SLVERR);
            rd(ch_addr(7));
            chk_resp(r, `CBP_RESP_SLVERR);
            chk(d, 32'h00000000);
            // A reset in mid-run must bring back full duty over written values.
            @(posedge aclk);
            aresetn <= 1'b0;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            rd(ch_addr(1));
            chk(d, 32'h000000FF);
            gate_check({7{8'hFF}});
            $display("edge test done");
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // Reset for two cycles, then the tests in turn.
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_duty;
        t_edge;
        give_verdict;
    end
    // The tests need about 2400 cycles; this cuts a hang short.
    initial
    begin
        #400000;
        n_errors = n_errors + 1;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict;
    end
endmodule // cbp_balance_pwm_tb_top
